// ### slb_port.sv
`timescale 1ns/1ns
module slb_port
    import slb_pkg::*;
#(
    parameter int DATA_BITS = 8
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Backplane pins, active low; output enables active high
    input wire slb_pins_t BUS_PINS_I,
    output logic [15:0] SHARED_AD_O,
    output logic SHARED_AD_OE_O,
    output logic REPLY_STROBE_N_O,
    output logic REPLY_STROBE_OE_O,
    // Straps
    input wire logic [9:0] ADDRESS_STRAP_I,
    input wire logic [5:0] VECTOR_STRAP_I,
    // Interrupt logic
    input wire logic VECTOR_DRIVE_I,
    input wire logic VECTOR_SOURCE_SELECT_I,
    // Internal control lines
    output logic [3:0] SELECT_O,
    output logic HIGH_BYTE_LOAD_O,
    output logic LOW_BYTE_LOAD_O,
    output logic READ_DIRECTION_O,
    // Serial side
    input wire logic RX_LINE_I,
    input wire logic TX_SERIAL_I,
    output logic RX_SERIAL_O,
    output slb_line_ctl_t LINE_CTL_O,
    output logic [15:0] TX_CHAR_O,
    output logic TX_LOAD_O
);

    // ==========================================================
    // Parameter check
    if (DATA_BITS < 5 || DATA_BITS > 8) begin : g_bad_bits
        $error("DATA_BITS must lie in 5..8");
    end

    localparam logic [15:0] CHAR_MASK =
        16'((17'h0_0001 << DATA_BITS) - 17'h0_0001);

    // ==========================================================
    // Input synchronisers
    slb_pins_t pins_s1_q, pins_s2_q;
    logic [1:0] rx_line_s_q;
    logic sync_prev_q;

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pins_s1_q <= '1;
            pins_s2_q <= '1;
            rx_line_s_q <= 2'b11;
            sync_prev_q <= 1'b0;
        end else begin
            pins_s1_q <= BUS_PINS_I;
            pins_s2_q <= pins_s1_q;
            rx_line_s_q <= {rx_line_s_q[0], RX_LINE_I};
            sync_prev_q <= ~pins_s2_q.sync_n;
        end
    end

    logic sync_a, rd_a, wr_a, byte_a, bank_a, sync_rise;
    logic [15:0] int_bus;
    logic hit;
    assign sync_a = ~pins_s2_q.sync_n;
    assign rd_a = ~pins_s2_q.rd_n;
    assign wr_a = ~pins_s2_q.wr_n;
    assign byte_a = ~pins_s2_q.byte_n;
    assign bank_a = ~pins_s2_q.bank_n;
    assign sync_rise = sync_a & ~sync_prev_q;
    assign int_bus = ~pins_s2_q.ad;
    // Bits 15:13 not compared, bank select stands for them
    assign hit = bank_a && (int_bus[12:3] == ADDRESS_STRAP_I);

    // ==========================================================
    // Cycle control
    slb_state_t state_q;
    logic [2:0] addr_q;
    logic [CNT_W-1:0] cnt_q;
    logic read_dir_q;
    logic word_q;
    logic cnt_done;
    assign cnt_done = (cnt_q == CNT_W'(REPLY_CYC - 1));

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
        end else if (!sync_a) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (sync_rise && hit) begin
                        state_q <= ST_SEL;
                    end
                end
                ST_SEL: begin
                    if (rd_a) begin
                        state_q <= ST_RD_WAIT;
                    end else if (wr_a) begin
                        state_q <= ST_WR_WAIT;
                    end
                end
                ST_RD_WAIT: begin
                    if (!rd_a) begin
                        state_q <= ST_SEL;
                    end else if (cnt_done) begin
                        state_q <= ST_RD_REPLY;
                    end
                end
                ST_RD_REPLY: begin
                    if (!rd_a) begin
                        state_q <= ST_END;
                    end
                end
                ST_WR_WAIT: begin
                    if (!wr_a) begin
                        state_q <= ST_SEL;
                    end else if (cnt_done) begin
                        state_q <= ST_WR_REPLY;
                    end
                end
                ST_WR_REPLY: begin
                    if (!wr_a) begin
                        state_q <= ST_END;
                    end
                end
                ST_END: begin
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cnt_q <= '0;
        end else if (state_q == ST_RD_WAIT || state_q == ST_WR_WAIT) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end else begin
            cnt_q <= '0;
        end
    end

    // Latch low address bits at sync edge
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            addr_q <= 3'h0;
        end else if (state_q == ST_IDLE && sync_rise && hit) begin
            addr_q <= int_bus[2:0];
        end
    end

    // Word or byte decided when write strobe arrives
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            word_q <= 1'b1;
        end else if (state_q == ST_SEL) begin
            word_q <= ~byte_a;
        end
    end

    // Direction held to end of cycle, not to end of reply
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            read_dir_q <= 1'b0;
        end else if (!sync_a) begin
            read_dir_q <= 1'b0;
        end else if (state_q == ST_RD_WAIT && rd_a && cnt_done) begin
            read_dir_q <= 1'b1;
        end
    end

    logic cycle_on, writing, hb_act, lb_act, wr_commit;
    assign cycle_on = (state_q != ST_IDLE);
    assign writing = (state_q == ST_WR_WAIT || state_q == ST_WR_REPLY);
    assign hb_act = writing && (word_q || addr_q[0]);
    assign lb_act = writing && (word_q || !addr_q[0]);
    assign wr_commit = (state_q == ST_WR_WAIT) && wr_a && cnt_done;

    always_comb begin
        SELECT_O = 4'h0;
        if (cycle_on) begin
            SELECT_O[addr_q[2:1]] = 1'b1;
        end
    end
    assign HIGH_BYTE_LOAD_O = hb_act;
    assign LOW_BYTE_LOAD_O = lb_act;
    assign READ_DIRECTION_O = read_dir_q;

    // ==========================================================
    // Device registers
    logic [15:0] rx_status_q, rx_data_q, tx_status_q, tx_data_q;
    logic [15:0] wr_data;
    assign wr_data = int_bus;

    logic apb_wr;
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;

    function automatic logic [15:0] merge(input logic [15:0] old_v,
            input logic [15:0] new_v, input logic hb, input logic lb);
        merge = {hb ? new_v[15:8] : old_v[15:8],
                 lb ? new_v[7:0] : old_v[7:0]};
    endfunction : merge

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_status_q <= RX_STATUS_RST;
        end else if (wr_commit && addr_q[2:1] == 2'd0) begin
            rx_status_q <= merge(rx_status_q, wr_data, hb_act, lb_act);
        end else if (apb_wr && PADDR_I == OFS_RX_STATUS) begin
            rx_status_q <= PWDATA_I[15:0];
        end
    end

    // Receiver side fills this from APB, kept right-justified
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_data_q <= RX_DATA_RST;
        end else if (apb_wr && PADDR_I == OFS_RX_DATA) begin
            rx_data_q <= PWDATA_I[15:0] & CHAR_MASK;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tx_status_q <= TX_STATUS_RST;
        end else if (wr_commit && addr_q[2:1] == 2'd2) begin
            tx_status_q <= merge(tx_status_q, wr_data, hb_act, lb_act);
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tx_data_q <= TX_DATA_RST;
            TX_LOAD_O <= 1'b0;
        end else begin
            TX_LOAD_O <= wr_commit && addr_q[2:1] == 2'd3;
            if (wr_commit && addr_q[2:1] == 2'd3) begin
                tx_data_q <= merge(tx_data_q, wr_data, hb_act, lb_act);
            end
        end
    end
    assign TX_CHAR_O = tx_data_q & CHAR_MASK;

    // ==========================================================
    // Serial line control
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RX_SERIAL_O <= 1'b1;
            LINE_CTL_O <= '0;
        end else begin
            RX_SERIAL_O <= tx_status_q[TXS_LOOPBACK_BIT] ?
                TX_SERIAL_I : rx_line_s_q[1];
            LINE_CTL_O.loopback <= tx_status_q[TXS_LOOPBACK_BIT];
            LINE_CTL_O.baud_prog <= tx_status_q[TXS_BAUD_EN_BIT];
            // Code held at zero while programming is off
            LINE_CTL_O.baud_code <= tx_status_q[TXS_BAUD_EN_BIT] ?
                tx_status_q[TXS_BAUD_LSB +: 4] : 4'h0;
        end
    end

    // ==========================================================
    // Backplane drivers
    logic [15:0] vector_word, rd_word;
    assign vector_word = {7'h00, VECTOR_STRAP_I,
        VECTOR_SOURCE_SELECT_I, 2'b00};

    always_comb begin
        unique case (addr_q[2:1])
            2'd0: rd_word = rx_status_q;
            2'd1: rd_word = rx_data_q;
            2'd2: rd_word = tx_status_q & TXS_READ_MASK;
            2'd3: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SHARED_AD_O <= 16'hFFFF;
            SHARED_AD_OE_O <= 1'b0;
            REPLY_STROBE_OE_O <= 1'b0;
        end else begin
            // Vector overrides, no bank select needed
            SHARED_AD_O <= VECTOR_DRIVE_I ? ~vector_word : ~rd_word;
            SHARED_AD_OE_O <= VECTOR_DRIVE_I || (read_dir_q &&
                state_q == ST_RD_REPLY);
            REPLY_STROBE_OE_O <= VECTOR_DRIVE_I ||
                (state_q == ST_RD_REPLY && rd_a) ||
                (state_q == ST_WR_REPLY && wr_a);
        end
    end
    // Open drain: only ever pulls low
    assign REPLY_STROBE_N_O = 1'b0;

    // ==========================================================
    // APB read side, zero wait
    logic [15:0] apb_sel;
    logic apb_ok;
    always_comb begin
        apb_ok = 1'b1;
        apb_sel = 16'h0000;
        unique case (PADDR_I)
            OFS_RX_STATUS: apb_sel = rx_status_q;
            OFS_RX_DATA: apb_sel = rx_data_q;
            OFS_TX_STATUS: apb_sel = tx_status_q;
            OFS_TX_DATA: apb_sel = tx_data_q;
            OFS_PORT_STATE: apb_sel = {8'h00, read_dir_q, addr_q,
                cycle_on, 3'(state_q)};
            default: apb_ok = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else if (PSEL_I && !PENABLE_I) begin
            PRDATA_O <= {16'h0000, apb_sel};
            PSLVERR_O <= ~apb_ok;
        end
    end
    assign PREADY_O = 1'b1;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_read_granted;
        state_q == ST_RD_WAIT && rd_a && cnt_done;
    endsequence
    sequence s_reply_up;
        ##1 (state_q == ST_RD_REPLY && read_dir_q) ##1 REPLY_STROBE_OE_O;
    endsequence

    AST_LOOPBACK: assert property (
        tx_status_q[TXS_LOOPBACK_BIT] |=> RX_SERIAL_O == $past(TX_SERIAL_I))
        else $error("loopback path not taken");
    AST_RIGHT_JUST: assert property (
        (TX_CHAR_O & ~CHAR_MASK) == 16'h0000)
        else $error("character not right-justified");
    AST_BAUD_GATE: assert property (
        !tx_status_q[TXS_BAUD_EN_BIT] |=> LINE_CTL_O.baud_code == 4'h0)
        else $error("baud code without enable");
    AST_HIT: assert property (
        (state_q == ST_IDLE && $rose(state_q == ST_SEL)) or
        (state_q == ST_IDLE ##1 state_q == ST_SEL) |-> $past(hit))
        else $error("cycle started without address hit");
    AST_DIR_DRIVE: assert property (
        SHARED_AD_OE_O && !$past(VECTOR_DRIVE_I) |-> $past(read_dir_q))
        else $error("backplane driven without read direction");
    AST_VEC_WORD: assert property (
        VECTOR_DRIVE_I |=> SHARED_AD_O == ~$past(vector_word) &&
        SHARED_AD_O[15:9] == 7'h7F && SHARED_AD_O[1:0] == 2'b11)
        else $error("vector word wrong");
    AST_VEC_REPLY: assert property (
        VECTOR_DRIVE_I |=> REPLY_STROBE_OE_O && SHARED_AD_OE_O)
        else $error("vector drive without reply");
    AST_SELECT: assert property (
        cycle_on |-> SELECT_O == (4'h1 << addr_q[2:1]))
        else $error("select line decode wrong");
    AST_READ_TIME: assert property (
        s_read_granted |-> s_reply_up)
        else $error("read reply late");
    AST_READ_DELAY: assert property (
        $rose(state_q == ST_RD_WAIT || state_q == ST_WR_WAIT) && rd_a |->
        !(state_q == ST_RD_REPLY) [*8])
        else $error("reply earlier than minimum delay");
    AST_REPLY_DROP: assert property (
        state_q == ST_RD_REPLY && !rd_a && !VECTOR_DRIVE_I |=>
        !REPLY_STROBE_OE_O)
        else $error("reply held after read strobe dropped");
    AST_RELEASE: assert property (
        !sync_a |=> SELECT_O == 4'h0 && !READ_DIRECTION_O)
        else $error("select or direction held after sync");
    AST_BYTE_LOAD: assert property (
        writing && !word_q |-> HIGH_BYTE_LOAD_O != LOW_BYTE_LOAD_O)
        else $error("byte write loads both bytes");

endmodule : slb_port

// ### slb_pkg.sv
package slb_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int REPLY_DELAY_NS = 150;
    // Delay is nominal; round up so data is never early
    localparam int REPLY_CYC = (REPLY_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 5;

    // ==========================================================
    // APB register offsets
    localparam logic [7:0] OFS_RX_STATUS = 8'h00;
    localparam logic [7:0] OFS_RX_DATA = 8'h04;
    localparam logic [7:0] OFS_TX_STATUS = 8'h08;
    localparam logic [7:0] OFS_TX_DATA = 8'h0C;
    localparam logic [7:0] OFS_PORT_STATE = 8'h10;

    // ==========================================================
    // Fields and reset values
    localparam int TXS_LOOPBACK_BIT = 2;
    localparam int TXS_BAUD_EN_BIT = 11;
    localparam int TXS_BAUD_LSB = 12;
    localparam int VEC_SRC_BIT = 2;
    localparam logic [15:0] RX_STATUS_RST = 16'h0000;
    localparam logic [15:0] RX_DATA_RST = 16'h0000;
    localparam logic [15:0] TX_STATUS_RST = 16'h0000;
    localparam logic [15:0] TX_DATA_RST = 16'h0000;
    // Baud control bits are write only on backplane reads; APB reads them back
    localparam logic [15:0] TXS_READ_MASK = 16'h07FF;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [15:0] ad;
        logic bank_n;
        logic sync_n;
        logic byte_n;
        logic rd_n;
        logic wr_n;
    } slb_pins_t;

    typedef struct packed {
        logic [3:0] baud_code;
        logic baud_prog;
        logic loopback;
    } slb_line_ctl_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SEL, ST_RD_WAIT, ST_RD_REPLY,
        ST_WR_WAIT, ST_WR_REPLY, ST_END
    } slb_state_t;

endpackage : slb_pkg

// ### slb_bus_master.sv
`timescale 1ns/1ns
// ==========================================================
// Backplane master model, pins are active low
module slb_bus_master
    import slb_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Resolved wire levels
    input wire logic [15:0] ad_i,
    input wire logic reply_n_i,
    // Master drivers
    output slb_pins_t pins_o
);
    // Released lines float high through the bus pull-ups
    initial pins_o = '1;

    task automatic cycle(input logic wr, input logic bank,
            input logic [15:0] addr, input logic [15:0] wdata,
            input logic byte_mode, output logic [15:0] rdata,
            output int cyc, output logic ok);
        int i;
        rdata = '0;
        cyc = 0;
        ok = 1'b0;
        @(posedge clk_i);
        pins_o.ad <= ~addr;
        pins_o.bank_n <= ~bank;
        pins_o.byte_n <= ~(wr & byte_mode);
        repeat (4) @(posedge clk_i);
        pins_o.sync_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        pins_o.ad <= wr ? ~wdata : 16'hFFFF;
        pins_o.bank_n <= 1'b1;
        @(posedge clk_i);
        if (wr) begin
            pins_o.wr_n <= 1'b0;
        end else begin
            pins_o.rd_n <= 1'b0;
        end
        for (i = 0; i < 40 && !ok; i++) begin
            @(posedge clk_i);
            cyc++;
            ok = (reply_n_i === 1'b0);
        end
        if (ok && !wr) begin
            rdata = ~ad_i;
        end
        pins_o.rd_n <= 1'b1;
        pins_o.wr_n <= 1'b1;
        pins_o.ad <= 16'hFFFF;
        for (i = 0; i < 20 && reply_n_i === 1'b0; i++) begin
            @(posedge clk_i);
        end
        ok = ok && (reply_n_i !== 1'b0);
        pins_o.sync_n <= 1'b1;
        pins_o.byte_n <= 1'b1;
    endtask : cycle
endmodule : slb_bus_master

// ### serial_line_bus_slave_port_tb.sv
`timescale 1ns/1ns
module serial_line_bus_slave_port_tb
    import slb_pkg::*;
;
    // ==========================================================
    // Stimulus and wires
    localparam logic [9:0] ASTRAP = 10'h1C0;
    localparam logic [5:0] VSTRAP = 6'h2D;
    localparam logic [15:0] DEV = {3'b111, ASTRAP, 3'b000};
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, ad_oe, rep_n, rep_oe, hb, lb, rdir;
    logic vdrv = 0, vsrc = 0, rx_line = 1, tx_ser = 1, rx_ser, tx_load;
    logic [15:0] ad_o, tx_char, bus_ad;
    logic [3:0] sel, sel_seen;
    logic [1:0] ld_seen;
    logic dir_seen, load_seen;
    slb_line_ctl_t ctl;
    slb_pins_t m_pins, pins;
    int num_errors = 0, n_tests = 0, cycles = 0;

    // Wired-AND of the open-collector lines
    assign bus_ad = m_pins.ad & (ad_oe ? ad_o : 16'hFFFF);
    assign pins = {bus_ad, m_pins.bank_n, m_pins.sync_n, m_pins.byte_n,
        m_pins.rd_n, m_pins.wr_n};

    always #5 clk = ~clk;

    slb_port u_dut (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .BUS_PINS_I(pins), .SHARED_AD_O(ad_o),
        .SHARED_AD_OE_O(ad_oe), .REPLY_STROBE_N_O(rep_n),
        .REPLY_STROBE_OE_O(rep_oe), .ADDRESS_STRAP_I(ASTRAP),
        .VECTOR_STRAP_I(VSTRAP), .VECTOR_DRIVE_I(vdrv),
        .VECTOR_SOURCE_SELECT_I(vsrc), .SELECT_O(sel),
        .HIGH_BYTE_LOAD_O(hb), .LOW_BYTE_LOAD_O(lb),
        .READ_DIRECTION_O(rdir), .RX_LINE_I(rx_line),
        .TX_SERIAL_I(tx_ser), .RX_SERIAL_O(rx_ser), .LINE_CTL_O(ctl),
        .TX_CHAR_O(tx_char), .TX_LOAD_O(tx_load));

    slb_bus_master u_master (.clk_i(clk), .ad_i(bus_ad),
        .reply_n_i(~(rep_oe & ~rep_n)), .pins_o(m_pins));

    // Sticky monitors, sampled mid-cycle to stay clear of the edge
    always @(negedge clk) begin
        sel_seen = sel_seen | sel;
        ld_seen = ld_seen | {hb, lb};
        dir_seen = dir_seen | rdir;
        load_seen = load_seen | tx_load;
    end

    // ==========================================================
    // Shared tasks
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            $display("Error at %0t: run hung", $time);
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd,
            output logic err);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 20 && pready !== 1'b1; i++) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic bp(input logic wr, input logic bank,
            input logic [15:0] a, input logic [15:0] wd,
            input logic bm, output logic [15:0] rd, output logic ok);
        int cyc;
        sel_seen = 0;
        ld_seen = 0;
        dir_seen = 0;
        load_seen = 0;
        u_master.cycle(wr, bank, a, wd, bm, rd, cyc, ok);
        if (ok) begin
            chk(cyc >= REPLY_CYC + 2 && cyc <= REPLY_CYC + 6, 1);
        end
        repeat (5) @(posedge clk);
        chk({sel, rdir}, 0);
    endtask : bp

    // ==========================================================
    // Scenarios
    task automatic t_apb;
        logic [31:0] d;
        logic e;
        chk({ctl, rdir, ad_oe, rep_oe, sel, rx_ser}, 1);
        // Port state read too: idle, nothing latched
        for (int i = 0; i < 5; i++) begin
            apb(0, 8'(i * 4), 0, d, e);
            chk(d, 0);
            chk(e, 0);
        end
        apb(0, 8'h14, 0, d, e);
        chk(e, 1);
        apb(1, OFS_RX_DATA, 32'h0000_01FF, d, e);
        apb(1, OFS_TX_STATUS, 32'h0000_FFFF, d, e);
        apb(0, OFS_TX_STATUS, 0, d, e);
        chk(d, 0);
        apb(0, OFS_RX_DATA, 0, d, e);
        chk(d, 32'h0000_00FF);
        $display("t_apb done");
    endtask : t_apb

    task automatic t_read;
        logic [15:0] d, a;
        logic ok;
        for (int i = 0; i < 4; i++) begin
            a = DEV | 16'(i * 2);
            if (i[0]) begin
                a = a & 16'h1FFF;
            end
            bp(0, 1, a, 0, 0, d, ok);
            chk(ok, 1);
            chk(sel_seen, 32'(1 << i));
            chk(dir_seen, 1);
            if (i == 1) begin
                chk(d, 16'h00FF);
            end
            if (i == 3) begin
                chk(d, 0);
            end
        end
        bp(0, 1, DEV ^ 16'h0008, 0, 0, d, ok);
        chk({ok, sel_seen}, 0);
        bp(0, 0, DEV, 0, 0, d, ok);
        chk({ok, sel_seen}, 0);
        $display("t_read done");
    endtask : t_read

    task automatic t_write;
        logic [15:0] d;
        logic ok;
        logic [31:0] w;
        logic e;
        bp(1, 1, DEV | 16'h0004, 16'hA804, 0, d, ok);
        chk({ok, dir_seen, ld_seen, ctl}, {4'b1011, 6'b1010_11});
        @(posedge clk);
        tx_ser <= 1'b0;
        repeat (5) @(posedge clk);
        chk(rx_ser, 0);
        bp(1, 1, DEV | 16'h0004, 16'h0000, 1, d, ok);
        chk({ok, ld_seen, ctl}, {3'b101, 6'b1010_10});
        repeat (5) @(posedge clk);
        chk(rx_ser, 1);
        rx_line <= 1'b0;
        repeat (5) @(posedge clk);
        chk(rx_ser, 0);
        bp(1, 1, DEV | 16'h0005, 16'h3000, 1, d, ok);
        chk({ok, ld_seen, ctl}, {3'b110, 6'b0000_00});
        bp(1, 1, DEV | 16'h0006, 16'h01A5, 0, d, ok);
        chk({ok, load_seen, tx_char}, {2'b11, 16'h00A5});
        // High byte of receive status, read back over APB
        bp(1, 1, DEV | 16'h0001, 16'h5A3C, 1, d, ok);
        chk({ok, ld_seen}, 3'b110);
        apb(0, OFS_RX_STATUS, 0, w, e);
        chk(w, 32'h0000_5A00);
        $display("t_write done");
    endtask : t_write

    task automatic t_vector;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            vdrv <= 1'b1;
            vsrc <= s[0];
            repeat (3) @(posedge clk);
            #1;
            chk({ad_oe, rep_oe, ad_o}, {2'b11, ~{7'b0, VSTRAP, s[0], 2'b0}});
            @(posedge clk);
            // Request withdrawn only after it was acknowledged
            vdrv <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            chk({ad_oe, rep_oe}, 0);
        end
        $display("t_vector done");
    endtask : t_vector

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_apb();
        t_read();
        t_write();
        t_vector();
        final_report();
    end
endmodule : serial_line_bus_slave_port_tb
